// ---- design/rx_frame_control.sv ----
// Receive and transceive control for a Type A contactless reader.
// Assumes demodulator, transmitter and FIFO share clk; no pin sync needed.
// Function
// - Command 16h starts the receiver; decoded bytes go to the FIFO.
// - Receive starts by command or after transceive transmit ends.
// - Wait counter counts down per bit clock; prepare at 3..1, listen at 0.
// - Decoding starts only when signal strength exceeds minimum level.
// - Decoder stops when signal is lost and sets the done flag.
// - Wait for start of frame, then pack bits into bytes for the FIFO.
// - End pattern or weak signal stops reception, goes idle, raises flags.
// - Checksum enabled expects one byte if short select, else two.
// - Delay buffer hides a good checksum; a bad one flushes everything.
// - Parity enabled checks a parity bit after each byte, odd or even.
// - Both halves modulated above collision level flag a collision.
// - Reception continues after collision; collided bit is delivered as one.
// - Zero-after-collision forces all later bits to zero.
// - First collision position recorded; start is 0, data from 1.
// - Collision in start gives framing error and no FIFO writes.
// - Alignment offsets the first byte and clears after reception.
// - Last-bits status tells valid low bits of final byte.
// - With alignment and parity, first parity bit is not checked.
// - Framing error on missing start; checksum error on mismatch or short.
// - Command 1Eh transmits from FIFO then starts receive.
// - Modem phase shows idle, transmit phases, transit and wait codes.
// - Modem phase reads 110 while listening.
`timescale 1ns/10ps
module rx_frame_control
    import rx_frame_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Command and transmitter
    input wire logic cmd_write,
    input wire logic [5:0] cmd_code,
    input wire logic tx_done,
    input wire logic [1:0] tx_phase,
    output logic tx_start,
    // Configuration
    input wire logic bit_tick,
    input wire logic [7:0] receive_wait_count,
    input wire logic [3:0] min_signal_level,
    input wire logic [3:0] collision_level,
    input wire redundancy_config_s redundancy_config,
    input wire logic zero_after_collision,
    input wire logic align_write,
    input wire logic [2:0] align_value,
    // Demodulator
    input wire half_bits_s demod,
    input wire logic [3:0] signal_strength,
    input wire logic eof_detect,
    output logic rx_prepare,
    output logic rx_active,
    // FIFO write side
    output logic fifo_wr,
    output logic [7:0] fifo_data,
    // Status
    output logic [2:0] modem_phase,
    input wire logic done_clear,
    output logic receive_done_flag,
    output logic collision_error,
    output logic parity_error,
    output logic framing_error,
    output logic checksum_error,
    output logic [7:0] collision_position,
    output logic [2:0] rx_valid_last_bits,
    output logic [2:0] rx_bit_alignment
);

    // ========================================
    // Checksum step, one byte LSB first
    function automatic logic [15:0] crc_step(input logic [15:0] c_in,
                                             input logic [7:0] d,
                                             input logic short_sel);
        logic [15:0] c;
        logic fb;
        c = c_in;
        fb = 1'b0;
        for (int i = 0; i < 8; i++) begin
            fb = c[0] ^ d[i];
            c = c >> 1;
            if (fb) begin
                c = c ^ (short_sel ? SHORT_CHECKSUM_SELECT_POLY : CRC16_POLY);
            end
        end
        return c;
    endfunction

    // ========================================
    // State
    rx_state_e st_q, st_d;
    logic [7:0] wait_q;
    logic [2:0] align_q;
    logic sof_pend_q, par_pend_q, first_par_q, par_acc_q;
    logic [3:0] fill_q;
    logic [7:0] byte_q;
    logic has_bits_q, zac_q, suppress_q, coll_seen_q;
    logic [7:0] bitno_q;
    logic [7:0] dly_q [0:1];
    logic [1:0] held_q, seen_q;
    logic [15:0] crc_q;
    logic fifo_wr_q;
    logic [7:0] fifo_data_q;
    logic done_q, coll_err_q, par_err_q, frm_err_q, crc_err_q;
    logic [7:0] pos_q;
    logic [2:0] last_q;

    // ========================================
    // Commands and sequencing
    wire cmd_idle = cmd_write && (cmd_code == CMD_IDLE);
    wire cmd_rx = cmd_write && (cmd_code == CMD_RECEIVE);
    wire cmd_trx = cmd_write && (cmd_code == CMD_TRANSCEIVE);
    wire sig_ok = signal_strength > min_signal_level;
    wire rx_end = eof_detect || !sig_ok;
    wire start_rx = st_q == ST_GO_RX;
    wire [1:0] depth = !redundancy_config.rx_checksum_enable ? DEPTH_NONE :
        (redundancy_config.short_checksum_select ? DEPTH_ONE : DEPTH_TWO);
    wire crc_bad = (depth != DEPTH_NONE) &&
        ((crc_q != '0) || (seen_q < depth));
    wire flushing = (st_q == ST_FLUSH) && crc_bad && (held_q != DEPTH_NONE);
    wire flush_done = !flushing;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: begin
                if (cmd_rx) st_d = ST_GO_RX;
                else if (cmd_trx) st_d = ST_TX;
            end
            ST_TX: if (tx_done) st_d = ST_GO_RX;
            ST_GO_RX: st_d = ST_WAIT;
            ST_WAIT: if (wait_q == WAIT_DONE) st_d = ST_LISTEN;
            ST_LISTEN: if (sig_ok) st_d = ST_DECODE;
            ST_DECODE: if (rx_end) st_d = ST_FINISH;
            ST_FINISH: st_d = ST_FLUSH;
            ST_FLUSH: if (flush_done) st_d = ST_IDLE;
        endcase
        if (cmd_idle) st_d = ST_IDLE;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= ST_IDLE;
            wait_q <= WAIT_DONE;
        end else begin
            st_q <= st_d;
            if (start_rx) begin
                wait_q <= receive_wait_count;
            end else if (st_q == ST_WAIT && bit_tick && wait_q != WAIT_DONE) begin
                wait_q <= wait_q - 8'h01;
            end
        end
    end

    // ========================================
    // Half-bit decoding
    wire mod_a = demod.first_amp > min_signal_level;
    wire mod_b = demod.second_amp > min_signal_level;
    wire [3:0] weaker = (demod.first_amp < demod.second_amp) ?
        demod.first_amp : demod.second_amp;
    wire coll = mod_a && mod_b && (weaker > collision_level);
    wire raw = demod.first_amp > demod.second_amp;
    wire bit_ev = (st_q == ST_DECODE) && demod.valid;
    wire sof_ev = bit_ev && sof_pend_q;
    wire par_ev = bit_ev && !sof_pend_q && par_pend_q;
    wire dat_ev = bit_ev && !sof_pend_q && !par_pend_q;
    wire dat_val = zac_q ? 1'b0 : (coll ? 1'b1 : raw);
    wire par_exp = par_acc_q ^ redundancy_config.odd_parity_select;
    wire par_skip = first_par_q && (align_q != 3'h0);
    wire par_bad = par_ev && !par_skip && (coll || (raw != par_exp));
    wire byte_done = dat_ev && (fill_q[2:0] == LAST_BIT);
    wire part_ev = (st_q == ST_FINISH) && has_bits_q;
    wire push = byte_done || part_ev;

    logic [7:0] byte_nx;
    always_comb begin
        byte_nx = byte_q;
        byte_nx[fill_q[2:0]] = dat_val;
    end
    wire [7:0] push_data = byte_done ? byte_nx : byte_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sof_pend_q <= 1'b1;
            par_pend_q <= 1'b0;
            first_par_q <= 1'b1;
            par_acc_q <= 1'b0;
            fill_q <= '0;
            byte_q <= '0;
            has_bits_q <= 1'b0;
            bitno_q <= POS_FIRST;
            zac_q <= 1'b0;
        end else if (start_rx) begin
            sof_pend_q <= 1'b1;
            par_pend_q <= 1'b0;
            first_par_q <= 1'b1;
            fill_q <= {1'b0, align_q};
            byte_q <= '0;
            has_bits_q <= 1'b0;
            bitno_q <= POS_FIRST;
            zac_q <= 1'b0;
        end else begin
            if (sof_ev) sof_pend_q <= 1'b0;
            if (par_ev) begin
                par_pend_q <= 1'b0;
                first_par_q <= 1'b0;
            end
            if (dat_ev) begin
                bitno_q <= bitno_q + 8'h01;
                zac_q <= zac_q || (coll && zero_after_collision);
                byte_q <= byte_done ? 8'h00 : byte_nx;
                has_bits_q <= !byte_done;
                fill_q <= byte_done ? 4'h0 : fill_q + 4'h1;
                if (byte_done) begin
                    par_pend_q <= redundancy_config.parity_check_enable;
                    par_acc_q <= ^byte_nx;
                end
            end
            if (part_ev) has_bits_q <= 1'b0;
        end
    end

    // ========================================
    // Checksum delay buffer and FIFO writes
    // Holding the last one or two bytes lets a good checksum vanish.
    wire pass = push && (held_q >= depth);
    wire emit = (pass || flushing) && !suppress_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            held_q <= DEPTH_NONE;
            seen_q <= DEPTH_NONE;
            crc_q <= CRC16_INIT;
            dly_q[0] <= '0;
            dly_q[1] <= '0;
        end else if (start_rx) begin
            held_q <= DEPTH_NONE;
            seen_q <= DEPTH_NONE;
            crc_q <= redundancy_config.short_checksum_select ? SHORT_CHECKSUM_SELECT_INIT : CRC16_INIT;
        end else if (push) begin
            crc_q <= crc_step(crc_q, push_data,
                              redundancy_config.short_checksum_select);
            seen_q <= (seen_q == DEPTH_TWO) ? seen_q : seen_q + 2'h1;
            if (held_q < depth) begin
                dly_q[held_q[0]] <= push_data;
                held_q <= held_q + 2'h1;
            end else if (depth == DEPTH_TWO) begin
                dly_q[0] <= dly_q[1];
                dly_q[1] <= push_data;
            end else begin
                dly_q[0] <= push_data;
            end
        end else if (flushing) begin
            dly_q[0] <= dly_q[1];
            held_q <= held_q - 2'h1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fifo_wr_q <= 1'b0;
            fifo_data_q <= '0;
        end else begin
            fifo_wr_q <= emit;
            if (emit) begin
                fifo_data_q <= (depth == DEPTH_NONE) ? push_data : dly_q[0];
            end
        end
    end

    // ========================================
    // Status flags; set wins over clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            coll_err_q <= 1'b0;
            par_err_q <= 1'b0;
            frm_err_q <= 1'b0;
            crc_err_q <= 1'b0;
            coll_seen_q <= 1'b0;
            suppress_q <= 1'b0;
            pos_q <= POS_SOF;
            last_q <= '0;
        end else if (start_rx) begin
            coll_err_q <= 1'b0;
            par_err_q <= 1'b0;
            frm_err_q <= 1'b0;
            crc_err_q <= 1'b0;
            coll_seen_q <= 1'b0;
            suppress_q <= 1'b0;
            pos_q <= POS_SOF;
        end else begin
            if ((sof_ev || dat_ev || par_ev) && coll) coll_err_q <= 1'b1;
            if (par_bad) par_err_q <= 1'b1;
            if (sof_ev && (coll || !raw)) frm_err_q <= 1'b1;
            if (sof_ev && coll) suppress_q <= 1'b1;
            if ((sof_ev || dat_ev) && coll && !coll_seen_q) begin
                coll_seen_q <= 1'b1;
                pos_q <= sof_ev ? POS_SOF : bitno_q;
            end
            if (st_q == ST_FLUSH && crc_bad) crc_err_q <= 1'b1;
            if (st_q == ST_FINISH) last_q <= has_bits_q ? fill_q[2:0] : 3'h0;
        end
    end

    wire done_set = (st_q == ST_FLUSH) && flush_done && !cmd_idle;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            done_q <= 1'b0;
            align_q <= '0;
        end else begin
            done_q <= done_set || (done_q && !done_clear);
            if (align_write) begin
                align_q <= align_value;
            end else if (st_q == ST_FINISH) begin
                align_q <= '0;
            end
        end
    end

    // ========================================
    // Modem phase and analog control
    always_comb begin
        unique case (st_q)
            ST_IDLE: modem_phase = PH_IDLE;
            ST_TX: modem_phase = {1'b0, tx_phase};
            ST_WAIT: modem_phase = PH_WAIT;
            ST_LISTEN, ST_DECODE: modem_phase = PH_LISTEN;
            ST_GO_RX, ST_FINISH, ST_FLUSH: modem_phase = PH_TRANSIT;
        endcase
    end

    assign rx_prepare = (st_q == ST_WAIT) && (wait_q <= PREP_TOP)
        && (wait_q != WAIT_DONE);
    assign rx_active = (st_q == ST_LISTEN) || (st_q == ST_DECODE);
    assign tx_start = st_q == ST_TX;
    assign fifo_wr = fifo_wr_q;
    assign fifo_data = fifo_data_q;
    assign receive_done_flag = done_q;
    assign collision_error = coll_err_q;
    assign parity_error = par_err_q;
    assign framing_error = frm_err_q;
    assign checksum_error = crc_err_q;
    assign collision_position = pos_q;
    assign rx_valid_last_bits = last_q;
    assign rx_bit_alignment = align_q;

endmodule // rx_frame_control

// ---- design/rx_frame_pkg.sv ----
// Constants, types and states of the receive frame control.
// Assumes one 40 MHz clock domain shared with the demodulator.
package rx_frame_pkg;
    // ========================================
    // Command codes
    localparam logic [5:0] CMD_IDLE = 6'h00;
    localparam logic [5:0] CMD_RECEIVE = 6'h16;
    localparam logic [5:0] CMD_TRANSCEIVE = 6'h1E;
    // ========================================
    // Modem phase codes
    localparam logic [2:0] PH_IDLE = 3'h0;
    localparam logic [2:0] PH_TRANSIT = 3'h4;
    localparam logic [2:0] PH_WAIT = 3'h5;
    localparam logic [2:0] PH_LISTEN = 3'h6;
    // ========================================
    // Counts and sizes
    localparam logic [7:0] PREP_TOP = 8'h03;
    localparam logic [7:0] WAIT_DONE = 8'h00;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [1:0] DEPTH_NONE = 2'h0;
    localparam logic [1:0] DEPTH_ONE = 2'h1;
    localparam logic [1:0] DEPTH_TWO = 2'h2;
    localparam logic [7:0] POS_SOF = 8'h00;
    localparam logic [7:0] POS_FIRST = 8'h01;
    // ========================================
    // Checksum, LSB first; 8-bit values are plain defaults
    localparam logic [15:0] CRC16_INIT = 16'h6363;
    localparam logic [15:0] CRC16_POLY = 16'h8408;
    localparam logic [15:0] SHORT_CHECKSUM_SELECT_INIT = 16'h00FF;
    localparam logic [15:0] SHORT_CHECKSUM_SELECT_POLY = 16'h008C;
    // ========================================
    // Carriers
    typedef struct packed {
        logic rx_checksum_enable;
        logic short_checksum_select;
        logic parity_check_enable;
        logic odd_parity_select;
    } redundancy_config_s;

    typedef struct packed {
        logic valid;
        logic [3:0] first_amp;
        logic [3:0] second_amp;
    } half_bits_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_TX = 3'b001,
        ST_GO_RX = 3'b010,
        ST_WAIT = 3'b011,
        ST_LISTEN = 3'b100,
        ST_DECODE = 3'b101,
        ST_FINISH = 3'b110,
        ST_FLUSH = 3'b111
    } rx_state_e;
endpackage

// ---- test/card_model.sv ----
// Card side model: half-bit amplitudes, signal level and end pattern.
// Assumes its tasks are called by the bench in the block's clock domain.
`timescale 1ns/10ps
module card_model
    import rx_frame_pkg::*;
(
    // Clock
    input wire logic clk,
    // Demodulator side
    output half_bits_s demod,
    output logic [3:0] signal_strength,
    output logic eof_detect
);
    localparam logic [3:0] AMP = 4'hC;
    initial begin
        demod = '{1'b0, 4'h0, 4'h0};
        signal_strength = 4'h0;
        eof_detect = 1'b0;
    end
    // Kind 0 zero, 1 one, 2 both halves modulated
    task automatic send_bit(input logic [1:0] kind);
        @(posedge clk);
        demod <= '{1'b1, (kind != 2'h0) ? AMP : 4'h0, (kind != 2'h1) ? AMP : 4'h0};
        @(posedge clk);
        // Released lines invert; stale data cannot pass
        demod <= '{1'b0, ~demod.first_amp, ~demod.second_amp};
        repeat (3) @(posedge clk);
    endtask
    task automatic begin_frame();
        @(posedge clk);
        signal_strength <= 4'hA;
        repeat (2) @(posedge clk);
    endtask
    // Ends by end pattern or by loss of signal
    task automatic end_frame(input logic use_eof);
        @(posedge clk);
        eof_detect <= use_eof;
        signal_strength <= use_eof ? 4'hA : 4'h0;
        @(posedge clk);
        eof_detect <= 1'b0;
        signal_strength <= 4'h0;
    endtask
endmodule // card_model

// ---- test/rx_frame_checker.sv ----
// Port assertions for the receive frame control.
// Assumes one clock domain; bound into every instance of the block.
`timescale 1ns/10ps
module rx_frame_checker
    import rx_frame_pkg::*;
(
    // Clock and inputs
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cmd_write,
    input wire logic [5:0] cmd_code,
    input wire logic [1:0] tx_phase,
    input wire logic done_clear,
    // Outputs watched
    input wire logic tx_start,
    input wire logic rx_prepare,
    input wire logic rx_active,
    input wire logic fifo_wr,
    input wire logic [2:0] modem_phase,
    input wire logic receive_done_flag,
    input wire logic collision_error,
    input wire logic parity_error,
    input wire logic framing_error,
    input wire logic checksum_error,
    input wire logic [7:0] collision_position
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire logic idle_now = modem_phase == PH_IDLE;
    wire logic take_rx = cmd_write && cmd_code == CMD_RECEIVE && idle_now;
    wire logic take_tx = cmd_write && cmd_code == CMD_TRANSCEIVE && idle_now;
    wire logic any_err = collision_error || parity_error || framing_error || checksum_error;
    // ========================================
    // Assertions
    rx_start_a: assert property (take_rx |=> modem_phase == PH_TRANSIT)
        else $error("receive not started");
    tx_start_a: assert property (take_tx |=> tx_start)
        else $error("transmit not started");
    tx_phase_a: assert property (tx_start |-> modem_phase == {1'b0, tx_phase})
        else $error("bad transmit phase");
    prepare_phase_a: assert property (rx_prepare |-> modem_phase == PH_WAIT)
        else $error("prepare outside wait");
    listen_phase_a: assert property (rx_active |-> modem_phase == PH_LISTEN)
        else $error("active without listen");
    flags_clear_a: assert property (take_rx |-> ##2 !any_err && collision_position == POS_SOF)
        else $error("stale error flags");
    sof_block_a: assert property (framing_error && collision_error
        && collision_position == POS_SOF |-> !fifo_wr)
        else $error("write after start collision");
    done_idle_a: assert property ($rose(receive_done_flag) |-> ##[0:1] idle_now)
        else $error("done without idle");
    abort_quiet_a: assert property (cmd_write && cmd_code == CMD_IDLE && !receive_done_flag
        && modem_phase == PH_LISTEN |=> idle_now && !receive_done_flag)
        else $error("abort not quiet");
    done_clear_a: assert property (receive_done_flag && done_clear && idle_now
        |=> !receive_done_flag)
        else $error("done not cleared");
    // ========================================
    // Covers
    rx_seen_c: cover property (take_rx);
    coll_seen_c: cover property ($rose(collision_error));
    crc_seen_c: cover property ($rose(checksum_error));
endmodule // rx_frame_checker

bind rx_frame_control rx_frame_checker i_checker (.clk, .arst_n, .cmd_write, .cmd_code,
    .tx_phase, .done_clear, .tx_start, .rx_prepare, .rx_active, .fifo_wr, .modem_phase,
    .receive_done_flag, .collision_error, .parity_error, .framing_error, .checksum_error,
    .collision_position);

// ---- test/rx_frame_control_tb.sv ----
// Self-checking bench for the receive frame control.
// Assumes card_model on the demodulator side and the bound checker.
`timescale 1ns/10ps
module rx_frame_control_tb;
    import rx_frame_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cmd_write = 1'b0;
    logic [5:0] cmd_code = CMD_IDLE;
    logic tx_done = 1'b0;
    logic [1:0] tx_phase = 2'h0;
    logic bit_tick = 1'b0;
    logic [7:0] receive_wait_count = 8'h04;
    logic [3:0] min_signal_level = 4'h2;
    logic [3:0] collision_level = 4'h5;
    redundancy_config_s redundancy_config = '0;
    logic zero_after_collision = 1'b0;
    logic align_write = 1'b0;
    logic [2:0] align_value = 3'h0;
    logic done_clear = 1'b0;
    half_bits_s demod;
    logic [3:0] signal_strength;
    logic eof_detect, tx_start, rx_prepare, rx_active, fifo_wr, receive_done_flag;
    logic collision_error, parity_error, framing_error, checksum_error;
    logic [7:0] fifo_data, collision_position;
    logic [2:0] modem_phase, rx_valid_last_bits, rx_bit_alignment;
    logic [7:0] got[$];
    logic [7:0] exp[$];
    logic [15:0] crc;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int tick_cnt = 0;

    rx_frame_control i_dut (.clk, .arst_n, .cmd_write, .cmd_code, .tx_done, .tx_phase,
        .tx_start, .bit_tick, .receive_wait_count, .min_signal_level, .collision_level,
        .redundancy_config, .zero_after_collision, .align_write, .align_value, .demod,
        .signal_strength, .eof_detect, .rx_prepare, .rx_active, .fifo_wr, .fifo_data,
        .modem_phase, .done_clear, .receive_done_flag, .collision_error, .parity_error,
        .framing_error, .checksum_error, .collision_position, .rx_valid_last_bits,
        .rx_bit_alignment);
    card_model i_card (.clk, .demod, .signal_strength, .eof_detect);

    // ========================================
    // Clock, bit clock, FIFO capture, hang guard
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        tick_cnt <= (tick_cnt + 1) % 4;
        bit_tick <= (tick_cnt == 3);
        if (fifo_wr === 1'b1) got.push_back(fifo_data);
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_count++;
            summarize();
        end
    end

    // ========================================
    // Tasks
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
        tests_run++;
        if (seen !== want) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, want, seen);
        end
    endtask
    task automatic command(input logic [5:0] code);
        @(posedge clk);
        cmd_write <= 1'b1;
        cmd_code <= code;
        @(posedge clk);
        cmd_write <= 1'b0;
    endtask
    task automatic wait_phase(input logic [2:0] ph);
        int n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (modem_phase !== ph && n < 400);
        check("modem_phase", modem_phase, ph);
    endtask
    task automatic open_rx(input logic [1:0] sof);
        int n = 0;
        int prep = 0;
        command(CMD_RECEIVE);
        do begin
            @(negedge clk);
            prep += (rx_prepare === 1'b1 && bit_tick === 1'b1);
            n++;
        end while (modem_phase !== PH_LISTEN && n < 400);
        check("prepare_ticks", 16'(prep), 16'h0003);
        check("rx_active", rx_active, 1'b1);
        i_card.begin_frame();
        i_card.send_bit(sof);
    endtask
    task automatic send_bits(input logic [15:0] v, input logic [15:0] coll, input int n);
        for (int i = 0; i < n; i++) begin
            i_card.send_bit(coll[i] ? 2'h2 : {1'b0, v[i]});
        end
    endtask
    // Parity kind 0 none, 1 correct, 2 wrong
    task automatic byte_out(input logic [7:0] b, input logic [7:0] coll, input logic [1:0] par);
        logic p;
        p = ^b ^ redundancy_config.odd_parity_select ^ (par == 2'h2);
        send_bits({8'h00, b}, {8'h00, coll}, 8);
        if (par != 2'h0) send_bits({15'h0000, p}, 16'h0000, 1);
    endtask
    task automatic close_rx(input logic use_eof, input string name);
        i_card.end_frame(use_eof);
        wait_phase(PH_IDLE);
        repeat (2) @(negedge clk);
        check("done_flag", receive_done_flag, 1'b1);
        check("fifo_count", 16'(got.size()), 16'(exp.size()));
        for (int i = 0; i < exp.size() && i < got.size(); i++) begin
            check("fifo_data", got[i], exp[i]);
        end
        got.delete();
        exp.delete();
        @(posedge clk);
        done_clear <= 1'b1;
        @(posedge clk);
        done_clear <= 1'b0;
        @(negedge clk);
        check("done_cleared", receive_done_flag, 1'b0);
        $display("test %s done", name);
    endtask
    function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] b, logic [15:0] poly);
        c = c ^ {8'h00, b};
        repeat (8) c = c[0] ? (c >> 1) ^ poly : c >> 1;
        return c;
    endfunction
    task automatic summarize();
        $display("tests_run %0d err_count %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ========================================
    // Sequence
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        check("phase_reset", modem_phase, PH_IDLE);
        check("flags_reset", {receive_done_flag, fifo_wr, tx_start}, 3'h0);
        open_rx(2'h1);
        byte_out(8'hA5, 8'h00, 2'h0);
        exp.push_back(8'hA5);
        close_rx(1'b1, "plain");
        check("last_bits", rx_valid_last_bits, 3'h0);
        for (int k = 0; k < 4; k++) begin
            redundancy_config <= '{1'b0, 1'b0, 1'b1, k[0]};
            open_rx(2'h1);
            byte_out(8'hA5, 8'h00, 2'h1);
            byte_out(8'h3C, 8'h00, k[1] ? 2'h2 : 2'h1);
            exp = '{8'hA5, 8'h3C};
            close_rx(1'b1, "parity");
            check("parity_error", parity_error, k[1]);
        end
        redundancy_config <= '0;
        for (int k = 0; k < 2; k++) begin
            zero_after_collision <= k[0];
            open_rx(2'h1);
            byte_out(8'hF0, 8'h04, 2'h0);
            byte_out(8'hFF, 8'h01, 2'h0);
            exp.push_back(k[0] ? 8'h04 : 8'hF4);
            exp.push_back(k[0] ? 8'h00 : 8'hFF);
            close_rx(1'b1, "collision");
            check("collision_error", collision_error, 1'b1);
            check("collision_pos", collision_position, 8'h03);
        end
        open_rx(2'h2);
        byte_out(8'h5A, 8'h00, 2'h0);
        close_rx(1'b0, "sof_collision");
        check("sof_flags", {framing_error, collision_error, collision_position}, 10'h300);
        open_rx(2'h0);
        close_rx(1'b1, "no_sof");
        check("framing_error", framing_error, 1'b1);
        for (int k = 0; k < 4; k++) begin
            redundancy_config <= '{1'b1, k < 2, 1'b0, 1'b0};
            crc = (k < 2) ? SHORT_CHECKSUM_SELECT_INIT : CRC16_INIT;
            open_rx(2'h1);
            for (int i = 0; i < ((k == 3) ? 1 : 2); i++) begin
                byte_out(8'h3C ^ 8'(i * 8'hBD), 8'h00, 2'h0);
                crc = crc_step(crc, 8'h3C ^ 8'(i * 8'hBD), (k < 2) ? SHORT_CHECKSUM_SELECT_POLY : CRC16_POLY);
                exp.push_back(8'h3C ^ 8'(i * 8'hBD));
            end
            crc = crc ^ 16'(k == 1);
            if (k == 1) exp.push_back(crc[7:0]);
            if (k < 3) byte_out(crc[7:0], 8'h00, 2'h0);
            if (k == 2) byte_out(crc[15:8], 8'h00, 2'h0);
            close_rx(1'b1, "checksum");
            check("checksum_error", checksum_error, k == 1 || k == 3);
        end
        redundancy_config <= '{1'b0, 1'b0, 1'b1, 1'b0};
        @(posedge clk);
        align_write <= 1'b1;
        align_value <= 3'h3;
        @(posedge clk);
        align_write <= 1'b0;
        @(negedge clk);
        check("align_set", rx_bit_alignment, 3'h3);
        open_rx(2'h1);
        send_bits(16'h0016, 16'h0000, 5);
        send_bits(16'h0000, 16'h0000, 1);
        send_bits(16'h0005, 16'h0000, 3);
        exp = '{8'hB0, 8'h05};
        close_rx(1'b0, "align");
        check("skip_parity", parity_error, 1'b0);
        check("last_bits", rx_valid_last_bits, 3'h3);
        check("align_clear", rx_bit_alignment, 3'h0);
        command(CMD_TRANSCEIVE);
        tx_phase <= 2'h2;
        @(negedge clk);
        check("tx_start", tx_start, 1'b1);
        check("tx_modem", modem_phase, 3'h2);
        @(posedge clk);
        tx_done <= 1'b1;
        @(posedge clk);
        tx_done <= 1'b0;
        wait_phase(PH_LISTEN);
        command(CMD_RECEIVE);
        @(negedge clk);
        check("refused", modem_phase, PH_LISTEN);
        command(CMD_IDLE);
        @(negedge clk);
        check("abort", {modem_phase, receive_done_flag}, 4'h0);
        $display("test transceive done");
        summarize();
    end
endmodule // rx_frame_control_tb
